// file: ilpc_pkg.sv
// ilpc_pkg.sv: constants and types for the interrupt and low-power control
// assumes: one 20 MHz clock, registers reached over the core's RAM-bit port
// How it works
// [RULE1] external pin falling edge sets external flag
// [RULE2] external mask bit 3 blocks when set
// [RULE3] timer B overflow sets its flag
// [RULE4] timer B mask bit 1 blocks when set
// [RULE5] timer C overflow sets its flag
// [RULE6] timer C mask bit 3 blocks when set
// [RULE7] serial done or suspend sets serial flag
// [RULE8] serial mask bit 3 blocks when set
// [RULE9] conversion done sets converter flag
// [RULE10] converter mask bit 1 blocks when set
// [RULE11] standby stops cpu clock, peripherals keep running
// [RULE12] standby exits on reset or any request
// [RULE13] stop halts oscillator, holds peripherals in reset
// [RULE14] leaving stop restarts program at zero
// [RULE15] ram kept flag tells reset from release
// [RULE16] release pin works only in stop
// [RULE17] only ram survives stop mode
// [RULE18] pending request with enable off cancels sleep
// [RULE19] stop clears pin functions, floats all pins
// [RULE20] asynchronous reset works in every mode
// [RULE21] request is flag and not mask, fixed priority
// [RULE22] global enable bit 0 gates all requests
// [RULE23] enable cleared on take, set by return
// [RULE24] software can never set a request flag
// [RULE25] flags stay set until cleared or reset
package ilpc_pkg;
  localparam logic [9:0] ILPC_OFS_EXT = 10'h000;
  localparam logic [9:0] ILPC_OFS_TMR = 10'h002;
  localparam logic [9:0] ILPC_OFS_SER = 10'h003;
  localparam int ILPC_BIT_ALLOW = 0;
  localparam int ILPC_BIT_EXT_FLAG = 2;
  localparam int ILPC_BIT_EXT_MASK = 3;
  localparam int ILPC_BIT_TB_FLAG = 0;
  localparam int ILPC_BIT_TB_MASK = 1;
  localparam int ILPC_BIT_TC_FLAG = 2;
  localparam int ILPC_BIT_TC_MASK = 3;
  localparam int ILPC_BIT_AD_FLAG = 0;
  localparam int ILPC_BIT_AD_MASK = 1;
  localparam int ILPC_BIT_SER_FLAG = 2;
  localparam int ILPC_BIT_SER_MASK = 3;
  localparam logic ILPC_RST_FLAG = 1'b0;
  localparam logic ILPC_RST_MASK = 1'b1;
  localparam logic ILPC_RST_ALLOW = 1'b0;
  localparam logic [2:0] ILPC_SRC_NONE = 3'h7;

  typedef enum logic [1:0] {ILPC_ACTIVE, ILPC_DOZE, ILPC_HALT} ilpc_mode_t;

  // one flag/mask pair per source, priority order ext,tb,tc,ad,ser
  typedef struct packed {
    logic ext;
    logic tmr_b;
    logic tmr_c;
    logic conv;
    logic ser;
  } ilpc_src_t;

  // core instruction strobes and ram-bit access
  typedef struct packed {
    logic doze_instruction;
    logic halt_instruction;
    logic return_from_irq_instruction;
    logic irq_taken;
    logic wr_en;
    logic [9:0] addr;
    logic [3:0] wdata;
  } ilpc_core_t;
endpackage

// file: ilpc_ctrl.sv
// ilpc_ctrl.sv: request flags, masks, global enable and mode controller
// assumes: core strobes are one-cycle pulses synchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module ilpc_ctrl
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire ilpc_pkg::ilpc_core_t core_in,
  input wire logic external_request_pin_in,
  input wire logic pin_function_select_b_in,
  input wire logic timer_b_ovf_in,
  input wire logic timer_c_ovf_in,
  input wire logic serial_done_in,
  input wire logic serial_suspend_in,
  input wire logic conv_done_in,
  input wire logic halt_release_pin_n_in,
  output logic [3:0] rdata_out,
  output logic irq_req_out,
  output logic [2:0] irq_src_out,
  output logic cpu_clk_run_out,
  output logic osc_run_out,
  output logic periph_reset_out,
  output logic pin_hiz_out,
  output logic restart_pc0_out,
  output logic ram_kept_flag_out,
  output logic insn_cancel_out,
  output var ilpc_pkg::ilpc_mode_t mode_out
);
  import ilpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  ilpc_src_t flag_reg, flag_next;
  ilpc_src_t mask_reg, mask_next;
  logic global_interrupt_allow_reg, global_interrupt_allow_next;
  logic ext_pin_reg, ext_pin_next;
  logic ram_kept_flag_reg, ram_kept_flag_next;
  logic restart_reg, restart_next;
  logic cancel_reg, cancel_next;
  ilpc_mode_t mode_reg, mode_next;
  ilpc_src_t pend;
  ilpc_src_t evt;
  ilpc_src_t clr;
  logic any_pend;

  // write to a bit of a control word clears only (flags never set by sw)
  function automatic logic clr_bit(input ilpc_core_t c, input logic [9:0] a,
                                   input int b);
    clr_bit = c.wr_en && c.addr == a && !c.wdata[b];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // hardware events and pending requests
  always_comb
  begin
    evt.ext = pin_function_select_b_in && ext_pin_reg
              && !external_request_pin_in; // [RULE1]
    evt.tmr_b = timer_b_ovf_in; // [RULE3]
    evt.tmr_c = timer_c_ovf_in; // [RULE5]
    evt.ser = serial_done_in || serial_suspend_in; // [RULE7]
    evt.conv = conv_done_in; // [RULE9]
    clr.ext = clr_bit(core_in, ILPC_OFS_EXT, ILPC_BIT_EXT_FLAG);
    clr.tmr_b = clr_bit(core_in, ILPC_OFS_TMR, ILPC_BIT_TB_FLAG);
    clr.tmr_c = clr_bit(core_in, ILPC_OFS_TMR, ILPC_BIT_TC_FLAG);
    clr.conv = clr_bit(core_in, ILPC_OFS_SER, ILPC_BIT_AD_FLAG);
    clr.ser = clr_bit(core_in, ILPC_OFS_SER, ILPC_BIT_SER_FLAG);
    pend = flag_reg & ~mask_reg; // [RULE2] [RULE4] [RULE6] [RULE8] [RULE10]
    any_pend = |pend;
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority encoder (source not gated); request gated by global enable and active mode
  always_comb
  begin
    irq_src_out = ILPC_SRC_NONE;
    if (pend.ser)
      irq_src_out = 3'h4;
    if (pend.conv)
      irq_src_out = 3'h3;
    if (pend.tmr_c)
      irq_src_out = 3'h2;
    if (pend.tmr_b)
      irq_src_out = 3'h1;
    if (pend.ext)
      irq_src_out = 3'h0; // [RULE21]
    irq_req_out = global_interrupt_allow_reg && any_pend
                  && mode_reg == ILPC_ACTIVE; // [RULE22]
  end

  ////////////////////////////////////////////////////////////////////////////
  // next values for flags, masks, enable and mode
  always_comb
  begin
    ext_pin_next = external_request_pin_in;
    // set wins over clear; flags held until cleared
    flag_next = (flag_reg & ~clr) | evt; // [RULE24] [RULE25]
    mask_next = mask_reg;
    global_interrupt_allow_next = global_interrupt_allow_reg;
    mode_next = mode_reg;
    ram_kept_flag_next = ram_kept_flag_reg;
    restart_next = 1'b0;
    cancel_next = 1'b0;
    if (core_in.wr_en)
    begin
      unique case (core_in.addr)
        ILPC_OFS_EXT:
        begin
          mask_next.ext = core_in.wdata[ILPC_BIT_EXT_MASK];
          global_interrupt_allow_next = core_in.wdata[ILPC_BIT_ALLOW];
        end
        ILPC_OFS_TMR:
        begin
          mask_next.tmr_b = core_in.wdata[ILPC_BIT_TB_MASK];
          mask_next.tmr_c = core_in.wdata[ILPC_BIT_TC_MASK];
        end
        ILPC_OFS_SER:
        begin
          mask_next.conv = core_in.wdata[ILPC_BIT_AD_MASK];
          mask_next.ser = core_in.wdata[ILPC_BIT_SER_MASK];
        end
        default:
        begin
          mask_next = mask_reg;
        end
      endcase
    end
    if (core_in.irq_taken)
      global_interrupt_allow_next = 1'b0; // [RULE23]
    if (core_in.return_from_irq_instruction)
      global_interrupt_allow_next = 1'b1; // [RULE23]
    unique case (mode_reg)
      ILPC_ACTIVE:
      begin
        if ((core_in.doze_instruction || core_in.halt_instruction)
            && !global_interrupt_allow_reg && any_pend)
          cancel_next = 1'b1; // [RULE18]
        else if (core_in.halt_instruction)
          mode_next = ILPC_HALT; // [RULE13]
        else if (core_in.doze_instruction)
          mode_next = ILPC_DOZE; // [RULE11]
      end
      ILPC_DOZE:
      begin
        if (any_pend)
          mode_next = ILPC_ACTIVE; // [RULE12]
      end
      ILPC_HALT:
      begin
        // peripherals held in reset: no new events while stopped
        flag_next = '0; // [RULE13]
        mask_next = '1;
        global_interrupt_allow_next = ILPC_RST_ALLOW;
        if (!halt_release_pin_n_in)
        begin
          mode_next = ILPC_ACTIVE; // [RULE16]
          ram_kept_flag_next = 1'b1; // [RULE15]
          restart_next = 1'b1; // [RULE14]
        end
      end
      // the spare state code falls back to active
      default:
      begin
        mode_next = ILPC_ACTIVE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; reset gives ram kept flag 0 and a restart at address 0
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in) // [RULE20]
    begin
      flag_reg <= {5{ILPC_RST_FLAG}};
      mask_reg <= {5{ILPC_RST_MASK}};
      global_interrupt_allow_reg <= ILPC_RST_ALLOW;
      ext_pin_reg <= 1'b1;
      ram_kept_flag_reg <= 1'b0; // [RULE15]
      restart_reg <= 1'b1; // [RULE14]
      cancel_reg <= 1'b0;
      mode_reg <= ILPC_ACTIVE;
    end
    else
    begin
      flag_reg <= flag_next;
      mask_reg <= mask_next;
      global_interrupt_allow_reg <= global_interrupt_allow_next;
      ext_pin_reg <= ext_pin_next;
      ram_kept_flag_reg <= ram_kept_flag_next;
      restart_reg <= restart_next;
      cancel_reg <= cancel_next;
      mode_reg <= mode_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and mode outputs
  always_comb
  begin
    rdata_out = 4'h0;
    unique case (core_in.addr)
      ILPC_OFS_EXT:
        rdata_out = {mask_reg.ext, flag_reg.ext, 1'b0,
                     global_interrupt_allow_reg};
      ILPC_OFS_TMR:
        rdata_out = {mask_reg.tmr_c, flag_reg.tmr_c, mask_reg.tmr_b,
                     flag_reg.tmr_b};
      ILPC_OFS_SER:
        rdata_out = {mask_reg.ser, flag_reg.ser, mask_reg.conv,
                     flag_reg.conv};
      default:
        rdata_out = 4'h0;
    endcase
  end

  // stop: oscillator off, peripherals reset, pins floated; only ram kept
  assign cpu_clk_run_out = mode_reg == ILPC_ACTIVE; // [RULE11]
  assign osc_run_out = mode_reg != ILPC_HALT; // [RULE13]
  assign periph_reset_out = mode_reg == ILPC_HALT; // [RULE17]
  assign pin_hiz_out = mode_reg == ILPC_HALT; // [RULE19]
  assign restart_pc0_out = restart_reg;
  assign ram_kept_flag_out = ram_kept_flag_reg;
  assign insn_cancel_out = cancel_reg;
  assign mode_out = mode_reg;
endmodule
`default_nettype wire

// file: ilpc_ctrl_chk.sv
// ilpc_ctrl_chk.sv: port assertions for the interrupt and low-power control
// assumes: bound into ilpc_ctrl, input names match its ports
`timescale 1ns/1ps
`default_nettype none
module ilpc_ctrl_chk
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire ilpc_pkg::ilpc_core_t core_in,
  input wire logic timer_b_ovf_in,
  input wire logic halt_release_pin_n_in,
  input wire logic [3:0] rdata_out,
  input wire logic irq_req_out,
  input wire logic cpu_clk_run_out,
  input wire logic osc_run_out,
  input wire logic pin_hiz_out,
  input wire logic restart_pc0_out,
  input wire logic ram_kept_flag_out,
  input wire logic insn_cancel_out,
  input wire ilpc_pkg::ilpc_mode_t mode_out
);
  import ilpc_pkg::*;
  ////////////////////////////////////////
  // all checks share the one clock and reset
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_HALT_PINS: assert property (
    mode_out == ILPC_HALT |-> pin_hiz_out && !osc_run_out)
    else $error("stop mode with pins or oscillator live");
  AST_DOZE_CLK: assert property (
    mode_out == ILPC_DOZE |-> !cpu_clk_run_out && osc_run_out)
    else $error("standby clocks wrong");
  AST_TB_SET: assert property (
    timer_b_ovf_in && mode_out == ILPC_ACTIVE && !core_in.halt_instruction
    |=> core_in.addr != ILPC_OFS_TMR || rdata_out[ILPC_BIT_TB_FLAG])
    else $error("timer b flag not set");
  AST_WAKE: assert property (
    mode_out == ILPC_HALT && !halt_release_pin_n_in |=> mode_out ==
    ILPC_ACTIVE && ram_kept_flag_out && restart_pc0_out)
    else $error("release pin wake wrong");
  AST_KEPT_HOLD: assert property (
    mode_out != ILPC_HALT && !core_in.halt_instruction
    |=> $stable(ram_kept_flag_out))
    else $error("ram kept flag moved outside stop");
  AST_CANCEL: assert property (
    insn_cancel_out |-> mode_out == ILPC_ACTIVE &&
    ($past(core_in.doze_instruction) || $past(core_in.halt_instruction)))
    else $error("cancel without sleep instruction");
  AST_TAKE_CLR: assert property (
    core_in.irq_taken && !core_in.return_from_irq_instruction
    |=> !irq_req_out) else $error("request after take");
  AST_RESTART: assert property (
    $rose(rst_n_in) |-> restart_pc0_out) else $error("no restart at 0");
endmodule
`default_nettype wire

// file: ilpc_periph_model.sv
// ilpc_periph_model.sv: peripheral events and external pin source
// assumes: fire bits are set by the bench just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module ilpc_periph_model
(
  input wire logic clk_in,
  input wire logic [5:0] fire_in,
  output logic ext_pin_out,
  output logic [4:0] pulse_out
);
  // pin idles high; one low cycle gives a falling edge
  initial ext_pin_out = 1'b1;
  initial pulse_out = 5'h00;
  always @(posedge clk_in)
  begin
    #2;
    ext_pin_out = !fire_in[0];
    pulse_out = fire_in[5:1];
  end
endmodule
`default_nettype wire

// file: test_interrupt_and_low_power_control.sv
// test_interrupt_and_low_power_control.sv: self-checking bench
// assumes: package, design, peripheral model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_and_low_power_control;
  import ilpc_pkg::*;
  logic clk_in = 1'b0, rst_n_in = 1'b0, sel = 1'b1, rel_n = 1'b1, en;
  logic [5:0] fire = 6'h00, f;
  logic [4:0] msk, fl, pulse;
  logic [3:0] rdata;
  logic [2:0] src;
  logic ext_pin, irq, cpu_clk, osc, prst, hiz, pc0, kept, cancel;
  ilpc_mode_t mode;
  ilpc_core_t core = '0;
  int failures = 0, n_compared = 0, cycles = 0, i;
  ilpc_periph_model ilpc_periph_model_inst (.clk_in(clk_in),
    .fire_in(fire), .ext_pin_out(ext_pin), .pulse_out(pulse));
  ilpc_ctrl ilpc_ctrl_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .core_in(core), .external_request_pin_in(ext_pin),
    .pin_function_select_b_in(sel), .timer_b_ovf_in(pulse[0]),
    .timer_c_ovf_in(pulse[1]), .conv_done_in(pulse[2]),
    .serial_done_in(pulse[3]), .serial_suspend_in(pulse[4]),
    .halt_release_pin_n_in(rel_n), .rdata_out(rdata), .irq_req_out(irq),
    .irq_src_out(src), .cpu_clk_run_out(cpu_clk), .osc_run_out(osc),
    .periph_reset_out(prst), .pin_hiz_out(hiz), .restart_pc0_out(pc0),
    .ram_kept_flag_out(kept), .insn_cancel_out(cancel), .mode_out(mode));
  ////////////////////////////////////////
  // clock and hang guard
  initial forever #25 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      final_report();
    end
  end
  // helpers: compare, wait, register access, strobes, events
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #5;
  endtask
  task automatic wr(input logic [9:0] a, input logic [3:0] d);
    core.addr = a;
    core.wdata = d;
    core.wr_en = 1'b1;
    tick(1);
    core.wr_en = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [9:0] a, input logic [3:0] e);
    core.addr = a;
    #1;
    chk(rdata, e);
  endtask
  task automatic cmd(input logic [3:0] s);
    {core.doze_instruction, core.halt_instruction,
      core.return_from_irq_instruction, core.irq_taken} = s;
    tick(1);
    {core.doze_instruction, core.halt_instruction,
      core.return_from_irq_instruction, core.irq_taken} = 4'h0;
  endtask
  task automatic pop(input logic [5:0] v);
    fire = v;
    tick(1);
    fire = 6'h00;
    tick(3);
  endtask
  // lowest index pending source wins
  function automatic logic [2:0] exp_src(input logic [4:0] r, m);
    exp_src = ILPC_SRC_NONE;
    for (int k = 4; k >= 0; k--)
      if (r[k] && !m[k]) exp_src = 3'(k);
  endfunction
  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial
  begin
    void'($urandom(32'hB97B74F4));
    tick(4);
    rst_n_in = 1'b1;
    rd(ILPC_OFS_EXT, 4'h8);
    rd(ILPC_OFS_SER, 4'hA);
    rd(10'h001, 4'h0);
    wr(ILPC_OFS_TMR, 4'hF);
    rd(ILPC_OFS_TMR, 4'hA);
    $display("reset test done");
    for (i = 0; i < 24; i++)
    begin
      msk = 5'($urandom);
      en = 1'($urandom);
      sel = (i < 6) | 1'($urandom);
      f = (i < 6) ? 6'h01 << i : 6'($urandom);
      wr(ILPC_OFS_TMR, {msk[2], 1'b0, msk[1], 1'b0});
      wr(ILPC_OFS_SER, {msk[4], 1'b0, msk[3], 1'b0});
      wr(ILPC_OFS_EXT, {msk[0], 2'b00, en});
      pop(f);
      fl = {f[5] | f[4], f[3:1], f[0] & sel};
      rd(ILPC_OFS_EXT, {msk[0], fl[0], 1'b0, en});
      rd(ILPC_OFS_TMR, {msk[2], fl[2], msk[1], fl[1]});
      rd(ILPC_OFS_SER, {msk[4], fl[4], msk[3], fl[3]});
      chk(irq, en && (fl & ~msk) != 0);
      chk(src, exp_src(fl, msk));
    end
    $display("event test done");
    wr(ILPC_OFS_EXT, 4'h9);
    wr(ILPC_OFS_TMR, 4'h0);
    pop(6'h02);
    chk(irq, 1'b1);
    cmd(4'h1);
    chk(irq, 1'b0);
    cmd(4'h2);
    chk(irq, 1'b1);
    wr(ILPC_OFS_EXT, 4'h8);
    cmd(4'h8);
    chk(cancel, 1'b1);
    tick(1);
    cmd(4'h4);
    chk({cancel, mode}, {1'b1, ILPC_ACTIVE});
    $display("enable and cancel test done");
    wr(ILPC_OFS_TMR, 4'h0);
    wr(ILPC_OFS_SER, 4'h0);
    cmd(4'h8);
    chk({mode, cpu_clk}, {ILPC_DOZE, 1'b0});
    rel_n = 1'b0;
    tick(1);
    rel_n = 1'b1;
    chk({mode, kept}, {ILPC_DOZE, 1'b0});
    pop(6'h02);
    chk(mode, ILPC_ACTIVE);
    wr(ILPC_OFS_TMR, 4'h0);
    cmd(4'h4);
    chk({mode, hiz, prst}, {ILPC_HALT, 2'b11});
    chk(osc, 1'b0);
    pop(6'h02);
    rd(ILPC_OFS_TMR, 4'hA);
    rel_n = 1'b0;
    tick(1);
    rel_n = 1'b1;
    chk({mode, kept, pc0}, {ILPC_ACTIVE, 2'b11});
    tick(1);
    cmd(4'h4);
    rst_n_in = 1'b0;
    tick(2);
    chk({mode, kept, pc0}, {ILPC_ACTIVE, 2'b01});
    rst_n_in = 1'b1;
    tick(2);
    $display("low power test done");
    final_report();
  end
endmodule
bind ilpc_ctrl ilpc_ctrl_chk ilpc_ctrl_chk_inst (.*);
`default_nettype wire
